/* File: design/flash_subsys.sv */
// Flash subsystem: address decode, shared external bus, flash array,
// nonvolatile special bytes and boot-from-flash security lock.
// Assumes core buses and programming utility run on clk.
`timescale 1ns/1ps
`default_nettype none
module flash_subsys
  import flash_subsys_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core program and data buses
  input wire flash_subsys_pkg::bus_req_t pmReq,
  input wire flash_subsys_pkg::bus_req_t dmReq,
  output logic [23:0] pmRdata,
  output logic [15:0] dmRdata,
  output logic pmAck,
  output logic dmAck,
  output logic busStall,
  // Core-side security routines
  input wire logic coreFullInit,
  input wire logic coreRegErase,
  // External programming utility
  input wire flash_subsys_pkg::util_req_t utilReq,
  output logic [23:0] utilRdata,
  output logic utilAck,
  output logic utilRefused,
  // Boot and status
  output logic [13:0] bootAddr,
  output logic bootValid,
  output logic secureSet,
  output logic busyFlag
);
  import flash_subsys_pkg::*;

  // ==========================================
  // Storage
  logic [WordW-1:0] flashMem [Words];
  logic [SprW-1:0] nvGeneralPurposeBytes [SprCount];
  logic [RegW-1:0] nvControlReg_r, nvAddressReg_r, nvDataLowReg_r, nvDataHighReg_r;
  logic secure_r;
  state_t state_r, state_nxt;
  logic [AddrW-1:0] initCnt_r;
  logic [23:0] pmRdata_r, utilRdata_r;
  logic [15:0] dmRdata_r;
  logic pmAck_r, dmAck_r, stall_r, utilAck_r, refused_r, bootValid_r;
  logic [13:0] bootAddr_r;
  bus_req_t heldDm_r;

  // ==========================================
  // Decoding
  function automatic region_t pmRegion(input logic [13:0] a);
    if (a <= PmVecHi) return RgnRam;
    if (a >= PmRamLo && a <= PmRamHi) return RgnRam;
    if (a >= PmRomLo && a <= PmRomHi) return RgnRom;
    if (a >= PmSec0Lo && a <= PmSec2Hi) return RgnFlash;
    return RgnNone;
  endfunction
  function automatic region_t dmRegion(input logic [13:0] a);
    if (a >= DmPeriLo && a <= DmPeriHi) return RgnReg;
    if (a >= DmRamLo && a <= DmRamHi) return RgnRam;
    if (a >= DmCoreLo && a <= DmCoreHi) return RgnReg;
    return RgnNone;
  endfunction
  // Sector index from flash offset: 0x000-0x0ff, 0x100-0x1ff, rest
  function automatic logic [1:0] sectorOf(input logic [AddrW-1:0] off);
    return (off[11:8] == 4'h0) ? 2'd0 : (off[11:8] == 4'h1) ? 2'd1 : 2'd2;
  endfunction
  function automatic logic ifHit(input logic [13:0] a);
    return a[13:2] == NvControlAddr[13:2];
  endfunction
  // Registers are passed in so that callers stay sensitive to them
  function automatic logic [15:0] ifSel(input logic [1:0] s, input logic [15:0] r0,
    input logic [15:0] r1, input logic [15:0] r2, input logic [15:0] r3);
    case (s)
      2'd0: return r0;
      2'd1: return r1;
      2'd2: return r2;
      default: return r3;
    endcase
  endfunction

  wire region_t pmRgn = pmRegion(pmReq.addr);
  wire region_t dmRgn = dmRegion(dmReq.addr);
  wire pmFlash = pmReq.valid && pmRgn == RgnFlash;
  wire [AddrW-1:0] pmOff = pmReq.addr[AddrW-1:0];
  // Data side reaches flash only through the interface registers, but a
  // second external transfer in the same cycle still costs one extra cycle.
  wire dmExt = dmReq.valid && dmRgn == RgnReg && dmReq.addr <= DmPeriHi;
  wire conflict = pmFlash && dmExt && !stall_r;
  wire utilOk = !secure_r && state_r == StIdle;
  wire utilGo = utilReq.cmd != CmdNone;
  wire [1:0] utilSec = sectorOf(utilReq.addr);
  wire dmIsIf = ifHit(dmReq.addr);
  wire [15:0] ifRead = ifSel(dmReq.addr[1:0], nvControlReg_r, nvAddressReg_r,
    nvDataLowReg_r, nvDataHighReg_r);
  // A delayed data read uses the address it was issued with, not what
  // the core drives during the overhead cycle.
  wire heldRd = heldDm_r.valid && !heldDm_r.write && ifHit(heldDm_r.addr);
  wire [15:0] heldRead = ifSel(heldDm_r.addr[1:0], nvControlReg_r, nvAddressReg_r,
    nvDataLowReg_r, nvDataHighReg_r);

  // ==========================================
  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      StBoot: state_nxt = StIdle;
      StIdle:
      begin
        if (conflict)
          state_nxt = StSecond;
        else if (coreFullInit)
          state_nxt = StInitErase;
      end
      StSecond: state_nxt = StIdle;
      StInitErase:
        if (initCnt_r == AddrW'(Words - 1))
          state_nxt = StIdle;
      default: state_nxt = StIdle;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= StBoot;
      initCnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      initCnt_r <= (state_r == StInitErase) ? initCnt_r + 1'b1 : '0;
    end
  end

  // Security code is nonvolatile: not reset; cleared only by core routines
  always_ff @(posedge clk)
  begin
    if (state_r == StInitErase && initCnt_r == AddrW'(Words - 1))
      secure_r <= 1'b0;
    else if (utilOk && utilReq.cmd == CmdSetSecure)
      secure_r <= 1'b1; // Set wins over a clear in the same cycle
    else if (coreRegErase && state_r == StIdle)
      secure_r <= 1'b0;
  end

  // ==========================================
  // Flash array and special bytes (no reset: nonvolatile)
  always_ff @(posedge clk)
  begin
    if (state_r == StInitErase)
      flashMem[initCnt_r] <= ErasedWord;
    else if (utilOk && utilReq.cmd == CmdEraseSector)
    begin
      for (int i = 0; i < Words; i++)
        if (sectorOf(AddrW'(i)) == utilSec)
          flashMem[i] <= ErasedWord;
    end
    else if (utilOk && utilReq.cmd == CmdProgram)
      flashMem[utilReq.addr] <= flashMem[utilReq.addr] & utilReq.data;
  end

  always_ff @(posedge clk)
  begin
    if (utilOk && utilReq.cmd == CmdEraseSpr)
      for (int i = 0; i < SprCount; i++)
        nvGeneralPurposeBytes[i] <= SprErased;
    else if (utilOk && utilReq.cmd == CmdWriteSpr)
      nvGeneralPurposeBytes[utilReq.addr[1:0]] <= utilReq.data[SprW-1:0];
  end

  // ==========================================
  // Interface registers: core writes are ignored, utility updates them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      nvControlReg_r <= RegReset;
      nvAddressReg_r <= RegReset;
      nvDataLowReg_r <= RegReset;
      nvDataHighReg_r <= RegReset;
    end
    else if (utilOk && utilGo)
    begin
      nvControlReg_r <= {13'h0000, utilReq.cmd};
      nvAddressReg_r <= {4'h0, utilReq.addr};
      nvDataLowReg_r <= utilReq.data[15:0];
      nvDataHighReg_r <= {8'h00, utilReq.data[23:16]};
    end
  end

  // ==========================================
  // Read paths and handshakes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pmRdata_r <= ReservedRead;
      dmRdata_r <= '0;
      pmAck_r <= 1'b0;
      dmAck_r <= 1'b0;
      stall_r <= 1'b0;
      utilRdata_r <= ReservedRead;
      utilAck_r <= 1'b0;
      refused_r <= 1'b0;
      heldDm_r <= '0;
    end
    else
    begin
      stall_r <= conflict;
      pmAck_r <= pmReq.valid && !(state_r == StSecond);
      pmRdata_r <= pmFlash ? flashMem[pmOff] : ReservedRead;
      heldDm_r <= dmReq;
      // Conflicting data access completes one cycle later
      dmAck_r <= (dmReq.valid && !conflict) || (state_r == StSecond);
      if (state_r == StSecond)
        dmRdata_r <= heldRd ? heldRead : '0;
      else
        dmRdata_r <= (dmReq.valid && dmIsIf && !dmReq.write) ? ifRead : '0;
      utilAck_r <= utilGo && utilOk;
      refused_r <= utilGo && !utilOk;
      utilRdata_r <= (utilOk && utilReq.cmd == CmdWriteSpr) ?
        {16'h0000, nvGeneralPurposeBytes[utilReq.addr[1:0]]} :
        (utilOk ? flashMem[utilReq.addr] : ReservedRead);
    end
  end

  // Boot vector: ROM monitor first, then flash jump if secure
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bootAddr_r <= BootRomAddr;
      bootValid_r <= 1'b0;
    end
    else if (state_r == StBoot)
    begin
      bootAddr_r <= secure_r ? BootFlashAddr : BootRomAddr;
      bootValid_r <= 1'b1;
    end
  end

  logic secureOut_r, busy_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      secureOut_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      secureOut_r <= secure_r;
      busy_r <= state_nxt == StInitErase;
    end
  end

  assign pmRdata = pmRdata_r;
  assign dmRdata = dmRdata_r;
  assign pmAck = pmAck_r;
  assign dmAck = dmAck_r;
  assign busStall = stall_r;
  assign utilRdata = utilRdata_r;
  assign utilAck = utilAck_r;
  assign utilRefused = refused_r;
  assign bootAddr = bootAddr_r;
  assign bootValid = bootValid_r;
  assign secureSet = secureOut_r;
  assign busyFlag = busy_r;
endmodule
`default_nettype wire

/* File: design/flash_subsys_pkg.sv */
// Package for the flash memory subsystem: address map, sizes, commands.
// Assumes a single 50 MHz clock domain shared with the processor core.
package flash_subsys_pkg;
  // ==========================================
  // Array geometry
  localparam int WordW = 24;
  localparam int Words = 4096;
  localparam int AddrW = 12;
  localparam int SprW = 8;
  localparam int SprCount = 4;
  localparam int RegW = 16;
  // ==========================================
  // Program memory map
  localparam logic [13:0] PmVecLo = 14'h0000;
  localparam logic [13:0] PmVecHi = 14'h002f;
  localparam logic [13:0] PmRamLo = 14'h0030;
  localparam logic [13:0] PmRamHi = 14'h01ff;
  localparam logic [13:0] PmRomLo = 14'h0800;
  localparam logic [13:0] PmRomHi = 14'h17ff;
  localparam logic [13:0] PmSec0Lo = 14'h2000;
  localparam logic [13:0] PmSec0Hi = 14'h20ff;
  localparam logic [13:0] PmSec1Lo = 14'h2100;
  localparam logic [13:0] PmSec1Hi = 14'h21ff;
  localparam logic [13:0] PmSec2Lo = 14'h2200;
  localparam logic [13:0] PmSec2Hi = 14'h2fff;
  localparam logic [13:0] BootRomAddr = 14'h0800;
  localparam logic [13:0] BootFlashAddr = 14'h2200;
  // ==========================================
  // Data memory map
  localparam logic [13:0] DmPeriLo = 14'h2000;
  localparam logic [13:0] DmPeriHi = 14'h20ff;
  localparam logic [13:0] DmRamLo = 14'h3800;
  localparam logic [13:0] DmRamHi = 14'h39ff;
  localparam logic [13:0] DmCoreLo = 14'h3c00;
  localparam logic [13:0] DmCoreHi = 14'h3fff;
  // Interface register addresses inside the peripheral window
  localparam logic [13:0] NvControlAddr = 14'h2000;
  localparam logic [13:0] NvAddressAddr = 14'h2001;
  localparam logic [13:0] NvDataLowAddr = 14'h2002;
  localparam logic [13:0] NvDataHighAddr = 14'h2003;
  localparam logic [15:0] RegReset = 16'h0000;
  localparam logic [23:0] ErasedWord = 24'hffffff;
  localparam logic [7:0] SprErased = 8'h00;
  localparam logic [23:0] ReservedRead = 24'h000000;
  // ==========================================
  // Programming-utility commands
  typedef enum logic [2:0] {
    CmdNone = 3'h0, CmdEraseSector = 3'h1, CmdProgram = 3'h2, CmdEraseSpr = 3'h3,
    CmdWriteSpr = 3'h4, CmdSetSecure = 3'h5, CmdFullInit = 3'h6
  } cmd_t;
  typedef enum logic [3:0] {
    StIdle = 4'b0001, StSecond = 4'b0010, StInitErase = 4'b0100, StBoot = 4'b1000
  } state_t;
  typedef enum logic [2:0] {
    RgnNone = 3'h0, RgnRam = 3'h1, RgnRom = 3'h2, RgnFlash = 3'h3, RgnReg = 3'h4
  } region_t;
  // One core bus request
  typedef struct packed {
    logic valid;
    logic write;
    logic [13:0] addr;
    logic [23:0] data;
  } bus_req_t;
  // External programming utility request
  typedef struct packed {
    cmd_t cmd;
    logic [AddrW-1:0] addr;
    logic [23:0] data;
  } util_req_t;
endpackage

/* File: verif/flash_subsys_checker.sv */
// Port-level assertions for the flash subsystem.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module flash_subsys_checker
  import flash_subsys_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core side
  input wire flash_subsys_pkg::bus_req_t pmReq,
  input wire flash_subsys_pkg::bus_req_t dmReq,
  input wire logic [23:0] pmRdata,
  input wire logic dmAck,
  input wire logic busStall,
  input wire logic coreRegErase,
  // Utility and status
  input wire flash_subsys_pkg::util_req_t utilReq,
  input wire logic utilAck,
  input wire logic utilRefused,
  input wire logic [13:0] bootAddr,
  input wire logic bootValid,
  input wire logic secureSet,
  input wire logic busyFlag
);
  // ==========================================
  // Decodes
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic pmFlash = pmReq.valid && pmReq.addr >= PmSec0Lo && pmReq.addr <= PmSec2Hi;
  wire logic dmPeri = dmReq.valid && dmReq.addr >= DmPeriLo && dmReq.addr <= DmPeriHi;
  wire logic pmRsvd = pmReq.valid && !pmReq.write && pmReq.addr > PmRamHi && pmReq.addr < PmRomLo;
  // ==========================================
  // Properties
  boot_rom_a: assert property (disable iff (1'b0) rst |=> bootAddr == BootRomAddr)
    else $error("boot address not ROM after reset");
  boot_flash_a: assert property ($rose(bootValid) && secureSet |-> bootAddr == BootFlashAddr)
    else $error("secure boot not at flash start");
  util_lock_a: assert property (secureSet && !$past(coreRegErase) && !$fell(busyFlag)
    && utilReq.cmd != CmdNone |=> utilRefused && !utilAck)
    else $error("utility served while locked");
  util_cause_a: assert property (utilAck |-> $past(utilReq.cmd) != CmdNone)
    else $error("utility ack without request");
  stall_cause_a: assert property (pmFlash && dmPeri && !busStall |=> busStall)
    else $error("shared bus conflict without overhead");
  stall_order_a: assert property (busStall |-> !dmAck ##1 dmAck)
    else $error("data ack not delayed by overhead cycle");
  rsvd_zero_a: assert property (pmRsvd |=> pmRdata == ReservedRead)
    else $error("reserved read not harmless");
  busy_span_a: assert property ($rose(busyFlag) |-> busyFlag [*8])
    else $error("full init ended too soon");
  init_clear_a: assert property ($fell(busyFlag) |-> ##[0:1] !secureSet)
    else $error("code not cleared after full init");
  reg_erase_a: assert property (coreRegErase && !busyFlag && !busStall && bootValid
    && utilReq.cmd != CmdSetSecure |-> ##[1:2] !secureSet)
    else $error("register erase left code set");
endmodule
bind flash_subsys flash_subsys_checker flash_subsys_checker_i (.clk, .rst, .pmReq, .dmReq,
  .pmRdata, .dmAck, .busStall, .coreRegErase, .utilReq, .utilAck, .utilRefused, .bootAddr,
  .bootValid, .secureSet, .busyFlag);
`default_nettype wire

/* File: verif/core_model.sv */
// Processor core model issuing program and data bus reads.
// Assumes the bench pulses a go line for each request.
`timescale 1ns/1ps
`default_nettype none
module core_model
  import flash_subsys_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic pmGo,
  input wire logic dmGo,
  input wire logic [13:0] pmAddr,
  input wire logic [13:0] dmAddr,
  // Requests
  output var flash_subsys_pkg::bus_req_t pmReq,
  output var flash_subsys_pkg::bus_req_t dmReq
);
  // ==========================================
  // Idle fields toggle so a stale value never looks like a request
  initial pmReq = '0;
  initial dmReq = '0;
  always @(posedge clk)
  begin
    pmReq <= '{pmGo, 1'b0, pmGo ? pmAddr : ~pmReq.addr, ~pmReq.data};
    dmReq <= '{dmGo, 1'b0, dmGo ? dmAddr : ~dmReq.addr, ~dmReq.data};
  end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the flash subsystem.
// Assumes the core model and checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_subsys_pkg::*;
  // ==========================================
  // Signals
  logic clk = 0, rst = 1, pmGo = 0, dmGo = 0, coreFullInit = 0, coreRegErase = 0;
  logic [13:0] pmAddr = 14'h0, dmAddr = 14'h0, bootAddr;
  logic [13:0] rsv [3] = '{14'h0200, 14'h1800, 14'h3000};
  util_req_t utilReq = '0;
  bus_req_t pmReq, dmReq;
  logic [23:0] pmRdata, utilRdata, w, v;
  logic [15:0] dmRdata;
  logic [11:0] a;
  logic [7:0] sb [4];
  int n;
  logic pmAck, dmAck, busStall, utilAck, utilRefused, bootValid, secureSet, busyFlag;
  logic [31:0] seed = 32'd59006;
  int num_errors = 0, check_count = 0, cyc = 0;
  always #10 clk = ~clk;
  core_model core_model_i (.clk, .pmGo, .dmGo, .pmAddr, .dmAddr, .pmReq, .dmReq);
  flash_subsys flash_subsys_i (.clk, .rst, .pmReq, .dmReq, .pmRdata, .dmRdata, .pmAck,
    .dmAck, .busStall, .coreFullInit, .coreRegErase, .utilReq, .utilRdata, .utilAck,
    .utilRefused, .bootAddr, .bootValid, .secureSet, .busyFlag);
  // ==========================================
  // Helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Programming can only clear bits
  function logic [23:0] progd(logic [23:0] o, logic [23:0] d);
    return o & d;
  endfunction
  task test_done;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(logic [23:0] got, logic [23:0] exp, string m);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task util(cmd_t c, logic [11:0] ad, logic [23:0] d);
    @(posedge clk) utilReq <= '{c, ad, d};
    @(posedge clk) utilReq <= '0;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      if (utilAck | utilRefused) break;
    end
  endtask
  task core(logic p, logic d, logic [13:0] pa, logic [13:0] da);
    @(posedge clk) {pmGo, dmGo, pmAddr, dmAddr} <= {p, d, pa, da};
    @(posedge clk) {pmGo, dmGo} <= 2'b00;
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk);
      if (p ? pmAck : dmAck) break;
    end
  endtask
  task reboot;
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      test_done;
    end
  end
  // ==========================================
  // Sequence
  initial
  begin
    repeat (11) @(posedge clk);
    @(negedge clk) chk(24'(bootAddr), 24'h000800, "reset boot");
    @(posedge clk) rst <= 1'b0;
    repeat (3) @(posedge clk);
    coreRegErase <= 1'b1;
    @(posedge clk) coreRegErase <= 1'b0;
    repeat (3) @(negedge clk);
    chk(24'(secureSet), 24'h0, "reg erase");
    util(CmdEraseSector, 12'h000, 24'h0);
    util(CmdEraseSector, 12'h200, 24'h0);
    chk(24'(utilAck), 24'h1, "erase ack");
    for (int i = 0; i < 4; i++)
    begin
      a = 12'h200 + 12'(i * 300);
      core(1'b1, 1'b0, {2'b10, a}, 14'h0);
      chk(pmRdata, ErasedWord, "erased");
      w = 24'(rnd());
      v = 24'(rnd());
      util(CmdProgram, a, w);
      util(CmdProgram, a, v);
      core(1'b1, 1'b0, {2'b10, a}, 14'h0);
      chk(pmRdata, progd(w, v), "program");
    end
    util(CmdProgram, 12'h0ff, 24'h0);
    util(CmdEraseSector, 12'h100, 24'h0);
    core(1'b1, 1'b0, 14'h20ff, 14'h0);
    chk(pmRdata, 24'h0, "sector kept");
    foreach (rsv[k])
    begin
      core(1'b1, 1'b0, rsv[k], 14'h0);
      chk(pmRdata, ReservedRead, "reserved");
    end
    core(1'b0, 1'b1, 14'h0100, 14'h0);
    chk(24'(dmRdata), 24'h0, "dm reserved");
    core(1'b1, 1'b1, 14'h2200, 14'h2001);
    chk(24'(busStall), 24'h1, "overhead");
    @(negedge clk) chk(24'(dmAck), 24'h1, "dm late");
    chk(24'(dmRdata), 24'h000100, "if address");
    util(CmdEraseSpr, 12'h0, 24'h0);
    for (int k = 0; k < 4; k++)
    begin
      sb[k] = 8'(rnd());
      util(CmdWriteSpr, 12'(k), {16'h0000, sb[k]});
      chk(utilRdata, 24'h0, "byte erased");
    end
    for (int k = 0; k < 4; k++)
    begin
      util(CmdWriteSpr, 12'(k), 24'h0);
      chk(utilRdata, {16'h0000, sb[k]}, "byte kept");
    end
    util(CmdSetSecure, 12'h0, 24'h0);
    @(negedge clk) chk(24'(secureSet), 24'h1, "secure");
    util(CmdProgram, 12'h200, 24'h0);
    chk(24'(utilRefused), 24'h1, "locked");
    chk(utilRdata, ReservedRead, "locked read");
    reboot;
    chk(24'(bootAddr), 24'h002200, "flash boot");
    chk(24'(bootValid), 24'h1, "boot valid");
    @(posedge clk) coreFullInit <= 1'b1;
    @(posedge clk) coreFullInit <= 1'b0;
    repeat (2) @(negedge clk);
    chk(24'(busyFlag), 24'h1, "busy");
    for (n = 0; n < 5000 && busyFlag; n++)
      @(negedge clk);
    chk(24'(n + 1), 24'(Words), "init span");
    repeat (2) @(negedge clk);
    chk(24'(secureSet), 24'h0, "unlocked");
    core(1'b1, 1'b0, 14'h2200, 14'h0);
    chk(pmRdata, ErasedWord, "wiped");
    reboot;
    chk(24'(bootAddr), 24'h000800, "rom boot");
    test_done;
  end
endmodule
`default_nettype wire
